/* dv/monitor_host_model.sv */
// Host side model that reads the monitor bank word by word
`timescale 1ns/100ps
`default_nettype none
module monitor_host_model (
   // Clock
   input wire logic core_clk,
   // Register read port
   output logic rd_en,
   output logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_err
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 16'h0000;
   end

   // One word read; a missing answer shows as unknown data
   task automatic rd16(input logic [15:0] a, output logic [15:0] d,
         output logic e);
      @(posedge core_clk);
      #1 rd_en = 1'b1;
      rd_addr = a;
      @(posedge core_clk);
      #1 rd_en = 1'b0;
      rd_addr = ~a; // Released address never repeats the last one
      d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
      e = (rd_valid === 1'b1) ? rd_err : 1'bx;
   endtask : rd16

   // Upper word first, so the lower half comes from the same sample
   task automatic rd32(input logic [15:0] a, output logic [31:0] v,
         output logic e);
      logic e1;
      rd16(a, v[31:16], e1);
      rd16(a + 16'h0001, v[15:0], e);
      e = e | e1;
   endtask : rd32
endmodule : monitor_host_model
`default_nettype wire

/* dv/motion_monitor_registers_tb.sv */
// Self-checking bench for the motion monitor register bank
`timescale 1ns/100ps
`default_nettype none
`include "motion_monitor_params.svh"
module motion_monitor_registers_tb;
   import motion_monitor_pkg::*;
   localparam int S_START = 0, S_DONE = 1, S_BEGIN = 2, S_PASS = 3;
   localparam int S_STOP = 4, S_ADV = 5, S_CLR = 6, S_LOAD = 7;
   logic core_clk, sys_rst, rd_en, rd_valid, rd_err, wrap_en, op_running;
   logic [15:0] rd_addr, rd_data, entry_next_no, loop_origin_no;
   word_t cmd_speed_hz, cmd_position, fb_position, wrap_len, fb_speed_rpm;
   word_t fb_speed_hz, dwell_left_ms, torque_ratio_in, op_destination;
   word_t exp_v, a_v, b_v, seed;
   logic signed [15:0] load_sample;
   logic [9:0] direct_in;
   logic [5:0] direct_out;
   logic [3:0] ext_in, virt_in;
   logic [1:0] diff_out, entry_link_mode;
   op_kind_t op_kind;
   logic [7:0] st;
   logic e_v;
   int err_count, total_checks, cycles;

   motion_monitor_registers u_motion_monitor_registers (
      .core_clk(core_clk), .sys_rst(sys_rst), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_err(rd_err), .cmd_speed_hz(cmd_speed_hz),
      .cmd_position(cmd_position), .fb_position(fb_position),
      .wrap_en(wrap_en), .wrap_len(wrap_len), .fb_speed_rpm(fb_speed_rpm),
      .fb_speed_hz(fb_speed_hz), .dwell_left_ms(dwell_left_ms),
      .torque_ratio_in(torque_ratio_in), .load_valid(st[S_LOAD]),
      .load_sample(load_sample), .direct_in(direct_in),
      .direct_out(direct_out), .ext_in(ext_in), .diff_out(diff_out),
      .virt_in(virt_in), .op_start(st[S_START]), .op_kind(op_kind),
      .op_destination(op_destination), .entry_link_mode(entry_link_mode),
      .entry_next_no(entry_next_no), .op_done(st[S_DONE]),
      .loop_begin(st[S_BEGIN]), .loop_origin_no(loop_origin_no),
      .loop_pass(st[S_PASS]), .loop_stop(st[S_STOP]),
      .advance_event(st[S_ADV]), .capture_clear(st[S_CLR]),
      .op_running(op_running));

   monitor_host_model u_monitor_host_model (
      .core_clk(core_clk), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));

   // Clock generation
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         end_sim();
      end
   end

   // Xorshift source, fixed start so every run repeats
   function automatic word_t rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Packed pin word as the monitor lays it out
   function automatic word_t pins_exp();
      return {6'h00, virt_in, diff_out, ext_in, direct_out, direct_in};
   endfunction : pins_exp

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Reads a mapped monitor and expects no error flag
   task automatic chk_reg(input logic [15:0] a, input word_t exp);
      word_t v;
      logic e;
      u_monitor_host_model.rd32(a, v, e);
      check(v, exp);
      check({31'h0000_0000, e}, 32'h0000_0000);
   endtask : chk_reg

   // One-cycle strobe on a single sequencing input
   task automatic strobe(input int b);
      @(posedge core_clk);
      #1 st[b] = 1'b1;
      @(posedge core_clk);
      #1 st = 8'h00;
   endtask : strobe

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task automatic end_sim();
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   initial begin
      seed = 32'h0000_0031;
      {err_count, total_checks, cycles} = '0;
      {cmd_speed_hz, cmd_position, fb_position, wrap_len} = '0;
      {fb_speed_rpm, fb_speed_hz, dwell_left_ms, torque_ratio_in} = '0;
      {op_destination, entry_next_no, loop_origin_no, load_sample} = '0;
      {direct_in, direct_out, ext_in, virt_in, diff_out} = '0;
      {entry_link_mode, wrap_en, st} = '0;
      op_kind = OP_OTHER;
      sys_rst = 1'b1;
      cyc(10);
      sys_rst = 1'b0;
      // Idle values straight after reset
      chk_reg(`ADDR_SUCCESSOR, `ENTRY_NONE);
      chk_reg(`ADDR_LOOP_START, `ENTRY_NONE);
      chk_reg(`ADDR_LOOP_ITER, `WORD_ZERO);
      chk_reg(`ADDR_CAP_CMD, `WORD_ZERO);
      // Wrap coordinate, including the exact wrap length
      wrap_len = 32'h0000_03E8;
      wrap_en = 1'b1;
      // Steps stay below one wrap length, as the tracker expects
      fb_position = 32'h0000_0384;
      cyc(1);
      fb_position = 32'h0000_0708;
      cyc(1);
      fb_position = 32'h0000_09C4;
      chk_reg(`ADDR_FB_POSITION, 32'h0000_01F4);
      fb_position = 32'h0000_0BB8;
      chk_reg(`ADDR_FB_POSITION, `WORD_ZERO);
      wrap_en = 1'b0;
      // Random live values
      for (int i = 0; i < 4; i++) begin
         {cmd_speed_hz, fb_position, fb_speed_rpm} = {rnd(), rnd(), rnd()};
         {fb_speed_hz, dwell_left_ms, torque_ratio_in} = {rnd(), rnd(), rnd()};
         {direct_in, direct_out, ext_in, diff_out, virt_in} = 26'(rnd());
         cyc(2);
         chk_reg(`ADDR_CMD_SPEED_HZ, cmd_speed_hz);
         chk_reg(`ADDR_FB_POSITION, fb_position);
         chk_reg(`ADDR_FB_SPEED_RPM, fb_speed_rpm);
         chk_reg(`ADDR_FB_SPEED_HZ, fb_speed_hz);
         chk_reg(`ADDR_DWELL_MS, dwell_left_ms);
         chk_reg(`ADDR_PIN_STATE, pins_exp());
         chk_reg(`ADDR_TORQUE, torque_ratio_in);
      end
      // Upper read freezes the lower half of the same pair
      u_monitor_host_model.rd16(`ADDR_TORQUE, a_v[31:16], e_v);
      torque_ratio_in = ~torque_ratio_in;
      u_monitor_host_model.rd16(`ADDR_TORQUE + 16'h0001, a_v[15:0], e_v);
      check(a_v, ~torque_ratio_in);
      // Gap in the map answers zero with the error flag
      u_monitor_host_model.rd32(16'h00D8, a_v, e_v);
      check(a_v, `WORD_ZERO);
      check({31'h0000_0000, e_v}, 32'h0000_0001);
      // Load of both signs adds up by magnitude
      a_v = rnd() & 32'h0000_7FFF;
      b_v = rnd() & 32'h0000_7FFF;
      load_sample = a_v[15:0];
      strobe(S_LOAD);
      load_sample = -b_v[15:0];
      strobe(S_LOAD);
      chk_reg(`ADDR_LOAD, a_v + b_v);
      // Eight listed move kinds; the first four show the destination
      entry_link_mode = 2'h1;
      for (int k = 0; k < 8; k++) begin
         {cmd_position, op_destination} = {rnd(), rnd()};
         op_kind = op_kind_t'(k);
         entry_next_no = 16'(k + 1);
         cyc(2);
         strobe(S_START);
         exp_v = (k < 4) ? op_destination : cmd_position;
         chk_reg(`ADDR_DESTINATION, exp_v);
         chk_reg(`ADDR_SUCCESSOR, 32'(k + 1));
      end
      // Other moves leave the target alone
      op_kind = OP_OTHER;
      op_destination = rnd();
      strobe(S_START);
      check({31'h0000_0000, op_running}, 32'h0000_0001);
      chk_reg(`ADDR_DESTINATION, exp_v);
      strobe(S_DONE);
      check({31'h0000_0000, op_running}, `WORD_ZERO);
      chk_reg(`ADDR_SUCCESSOR, 32'h0000_0008);
      entry_link_mode = `LINK_NONE;
      strobe(S_START);
      chk_reg(`ADDR_SUCCESSOR, `ENTRY_NONE);
      entry_link_mode = 2'h1;
      entry_next_no = `NEXT_FIELD_STOP;
      strobe(S_START);
      chk_reg(`ADDR_SUCCESSOR, `ENTRY_NONE);
      // Loop start, passes and stop
      loop_origin_no = 16'(rnd());
      strobe(S_BEGIN);
      for (int p = 0; p < 3; p++) strobe(S_PASS);
      chk_reg(`ADDR_LOOP_START, {16'h0000, loop_origin_no});
      chk_reg(`ADDR_LOOP_ITER, 32'h0000_0003);
      strobe(S_STOP);
      chk_reg(`ADDR_LOOP_START, `ENTRY_NONE);
      chk_reg(`ADDR_LOOP_ITER, `WORD_ZERO);
      // Advance event capture, overwrite, then clear
      for (int n = 0; n < 2; n++) begin
         {a_v, b_v} = {rnd(), rnd()};
         {cmd_position, fb_position} = {a_v, b_v};
         cyc(3);
         strobe(S_ADV);
         {cmd_position, fb_position} = {rnd(), rnd()};
         chk_reg(`ADDR_CAP_CMD, a_v);
         chk_reg(`ADDR_CAP_FB, b_v);
      end
      strobe(S_CLR);
      chk_reg(`ADDR_CAP_CMD, `WORD_ZERO);
      chk_reg(`ADDR_CAP_FB, `WORD_ZERO);
      end_sim();
   end
endmodule : motion_monitor_registers_tb
`default_nettype wire

/* src/advance_capture.sv */
// Latch of command and feedback position on the advance event
`timescale 1ns/100ps
`default_nettype none
`include "motion_monitor_params.svh"
module advance_capture (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Capture signals
   capture_if.latch cap
);
   import motion_monitor_pkg::*;

   // Event beats clear so a capture in the clearing cycle is kept
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cap.held_cmd <= `WORD_ZERO;
         cap.held_fb <= `WORD_ZERO;
         cap.held_valid <= 1'b0;
      end else if (cap.adv_pulse) begin
         cap.held_cmd <= cap.cmd_pos; // RULE14 RULE16
         cap.held_fb <= cap.fb_pos; // RULE15 RULE16
         cap.held_valid <= 1'b1;
      end else if (cap.clear_pulse) begin
         cap.held_cmd <= `WORD_ZERO; // RULE17
         cap.held_fb <= `WORD_ZERO; // RULE17
         cap.held_valid <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   capture_both_a: assert property (cap.adv_pulse |=> // RULE14
      cap.held_cmd == $past(cap.cmd_pos) &&
      cap.held_fb == $past(cap.fb_pos) && cap.held_valid)
      else $error("advance event did not capture both positions");
   capture_clear_a: assert property ( // RULE17
      cap.clear_pulse && !cap.adv_pulse |=>
      cap.held_cmd == `WORD_ZERO && cap.held_fb == `WORD_ZERO
      ##1 (cap.held_cmd == `WORD_ZERO || $past(cap.adv_pulse)))
      else $error("cleared capture did not read zero");
   capture_over_c: cover property (cap.held_valid && cap.adv_pulse);
endmodule : advance_capture
`default_nettype wire

/* src/capture_if.sv */
// Signals between the monitor bank and its advance-event latch
`timescale 1ns/100ps
`default_nettype none
interface capture_if;
   import motion_monitor_pkg::*;
   logic adv_pulse;
   logic clear_pulse;
   word_t cmd_pos;
   word_t fb_pos;
   word_t held_cmd;
   word_t held_fb;
   logic held_valid;

   modport owner (output adv_pulse, clear_pulse, cmd_pos, fb_pos,
      input held_cmd, held_fb, held_valid);
   modport latch (input adv_pulse, clear_pulse, cmd_pos, fb_pos,
      output held_cmd, held_fb, held_valid);
endinterface : capture_if
`default_nettype wire

/* src/motion_monitor_params.svh */
// Constants for the motion monitor register bank
// Function
// RULE1: Report present command speed in hertz at the first monitor address.
// RULE2: Report feedback position, on the wrap coordinate when wrapping is on.
// RULE3: Report feedback speed twice, once in r/min and once in hertz.
// RULE4: Report remaining drive-complete delay or dwell time in milliseconds.
// RULE5: Pack direct, extended, differential, virtual pin states in one word.
// RULE6: Report torque as a ratio of the maximum holding torque.
// RULE7: Accumulate load in internal units, both directions adding magnitude.
// RULE8: Positioning, inching, fast and offset homing show the destination.
// RULE9: Continuous, macro, jog and push homing moves show the start point.
// RULE10: Show successor entry number of running entry, kept after completion.
// RULE11: Successor number reads -1 for no link or a stop successor.
// RULE12: Report loop start entry, or -1 when no loop runs.
// RULE13: Report loop iteration count, or 0 outside a running loop.
// RULE14: Advance event captures the command position into a latch monitor.
// RULE15: The same advance event captures the feedback position too.
// RULE16: A further advance event overwrites the held positions.
// RULE17: Clearing the capture makes both capture monitors read zero; a same-cycle advance event wins and its capture is kept.
// RULE18: Each value is two 16-bit words, upper at even address.
`ifndef MOTION_MONITOR_PARAMS_SVH
`define MOTION_MONITOR_PARAMS_SVH

// Upper-word register addresses
`define ADDR_CMD_SPEED_HZ 16'h00CA
`define ADDR_FB_POSITION 16'h00CC
`define ADDR_FB_SPEED_RPM 16'h00CE
`define ADDR_FB_SPEED_HZ 16'h00D0
`define ADDR_DWELL_MS 16'h00D2
`define ADDR_PIN_STATE 16'h00D4
`define ADDR_TORQUE 16'h00D6
`define ADDR_LOAD 16'h00DA
`define ADDR_DESTINATION 16'h00DE
`define ADDR_SUCCESSOR 16'h00E0
`define ADDR_LOOP_START 16'h00E2
`define ADDR_LOOP_ITER 16'h00E4
`define ADDR_CAP_CMD 16'h00E6
`define ADDR_CAP_FB 16'h00E8

// Reset, idle and saturation values
`define WORD_ZERO 32'h0000_0000
`define ENTRY_NONE 32'hFFFF_FFFF
`define LOAD_FULL 32'hFFFF_FFFF
`define HALF_ZERO 16'h0000

// Entry link encodings
`define LINK_NONE 2'h0
`define NEXT_FIELD_STOP 16'hFFFF

// Pin state field positions
`define PIN_DIRECT_IN_LSB 0
`define PIN_DIRECT_OUT_LSB 10
`define PIN_EXT_IN_LSB 16
`define PIN_DIFF_OUT_LSB 20
`define PIN_VIRT_IN_LSB 22

`endif

/* src/motion_monitor_pkg.sv */
// Types shared by the motion monitor register bank
package motion_monitor_pkg;

   typedef logic [31:0] word_t;

   // Operation kinds reported by the motion core at each entry start
   typedef enum logic [3:0] {
      OP_POS_SD = 4'h0,
      OP_INCHING = 4'h1,
      OP_HS_HOME = 4'h2,
      OP_HOME_OFFSET = 4'h3,
      OP_CONT_SD = 4'h4,
      OP_CONT_MACRO = 4'h5,
      OP_JOG_MACRO = 4'h6,
      OP_HOME_PUSH = 4'h7,
      OP_OTHER = 4'h8
   } op_kind_t;

   // Run tracking states
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b01,
      RUN_ACTIVE = 2'b10
   } run_state_t;

   // Moves whose target monitor shows the destination
   function automatic logic shows_destination(op_kind_t k);
      return (k == OP_POS_SD) || (k == OP_INCHING) ||
             (k == OP_HS_HOME) || (k == OP_HOME_OFFSET);
   endfunction : shows_destination

   // Moves whose target monitor shows the start position
   function automatic logic shows_start(op_kind_t k);
      return (k == OP_CONT_SD) || (k == OP_CONT_MACRO) ||
             (k == OP_JOG_MACRO) || (k == OP_HOME_PUSH);
   endfunction : shows_start

endpackage : motion_monitor_pkg

/* src/motion_monitor_registers.sv */
// Read-only motion monitor register bank with 16-bit word read port
`timescale 1ns/100ps
`default_nettype none
`include "motion_monitor_params.svh"
module motion_monitor_registers (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register read port, 16-bit word addresses
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic rd_err,
   // Speeds, positions and timers from the motion core
   input wire motion_monitor_pkg::word_t cmd_speed_hz,
   input wire motion_monitor_pkg::word_t cmd_position,
   input wire motion_monitor_pkg::word_t fb_position,
   input wire logic wrap_en,
   input wire motion_monitor_pkg::word_t wrap_len,
   input wire motion_monitor_pkg::word_t fb_speed_rpm,
   input wire motion_monitor_pkg::word_t fb_speed_hz,
   input wire motion_monitor_pkg::word_t dwell_left_ms,
   input wire motion_monitor_pkg::word_t torque_ratio_in,
   // Load samples, signed per direction
   input wire logic load_valid,
   input wire logic signed [15:0] load_sample,
   // Pin states
   input wire logic [9:0] direct_in,
   input wire logic [5:0] direct_out,
   input wire logic [3:0] ext_in,
   input wire logic [1:0] diff_out,
   input wire logic [3:0] virt_in,
   // Operation sequencing
   input wire logic op_start,
   input wire motion_monitor_pkg::op_kind_t op_kind,
   input wire motion_monitor_pkg::word_t op_destination,
   input wire logic [1:0] entry_link_mode,
   input wire logic [15:0] entry_next_no,
   input wire logic op_done,
   // Loop sequencing
   input wire logic loop_begin,
   input wire logic [15:0] loop_origin_no,
   input wire logic loop_pass,
   input wire logic loop_stop,
   // Advance event capture
   input wire logic advance_event,
   input wire logic capture_clear,
   // Run status
   output logic op_running
);
   import motion_monitor_pkg::*;

   run_state_t run_r;
   word_t cmd_speed_r;
   word_t fb_report_r;
   word_t rpm_r;
   word_t fb_hz_r;
   word_t dwell_r;
   word_t pins_r;
   word_t torque_r;
   word_t load_acc_r;
   word_t target_r;
   word_t next_no_r;
   word_t loop_origin_r;
   word_t loop_count_r;
   word_t wrap_pos_r;
   word_t wrap_pos_nxt;
   word_t fb_prev_r;
   word_t lo_hold_r;
   logic [15:0] lo_hold_addr_r;
   logic lo_hold_valid_r;
   logic signed [32:0] fb_delta;
   logic signed [32:0] wrap_sum;
   logic [32:0] load_sum;
   word_t sel_word;
   logic sel_hit;
   logic [15:0] upper_addr;
   logic rd_lower;

   capture_if cap ();

   // Magnitude of a signed load sample, direction ignored
   function automatic logic [15:0] magnitude(logic signed [15:0] v);
      return v[15] ? 16'(-v) : 16'(v);
   endfunction : magnitude

   // Half of a 32-bit monitor chosen by the word address parity
   function automatic logic [15:0] half_of(word_t w, logic lower);
      return lower ? w[15:0] : w[31:16];
   endfunction : half_of

   // Monitor values are sampled each cycle so reads see one stable copy
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmd_speed_r <= `WORD_ZERO;
         rpm_r <= `WORD_ZERO;
         fb_hz_r <= `WORD_ZERO;
         dwell_r <= `WORD_ZERO;
         torque_r <= `WORD_ZERO;
         pins_r <= `WORD_ZERO;
      end else begin
         cmd_speed_r <= cmd_speed_hz; // RULE1
         rpm_r <= fb_speed_rpm; // RULE3
         fb_hz_r <= fb_speed_hz; // RULE3
         dwell_r <= dwell_left_ms; // RULE4
         torque_r <= torque_ratio_in; // RULE6
         pins_r <= `WORD_ZERO;
         pins_r[`PIN_DIRECT_IN_LSB +: 10] <= direct_in; // RULE5
         pins_r[`PIN_DIRECT_OUT_LSB +: 6] <= direct_out; // RULE5
         pins_r[`PIN_EXT_IN_LSB +: 4] <= ext_in; // RULE5
         pins_r[`PIN_DIFF_OUT_LSB +: 2] <= diff_out; // RULE5
         pins_r[`PIN_VIRT_IN_LSB +: 4] <= virt_in; // RULE5
      end
   end

   // Wrap coordinate follows the raw count by its per-cycle movement;
   // a step is assumed smaller than one wrap length
   always_comb begin
      fb_delta = $signed({fb_position[31], fb_position}) -
                 $signed({fb_prev_r[31], fb_prev_r});
      wrap_sum = $signed({1'b0, wrap_pos_r}) + fb_delta;
      if (wrap_len == `WORD_ZERO) begin
         wrap_pos_nxt = `WORD_ZERO;
      end else if (wrap_sum < 0) begin
         wrap_pos_nxt = 32'(wrap_sum + $signed({1'b0, wrap_len}));
      end else if (wrap_sum >= $signed({1'b0, wrap_len})) begin
         wrap_pos_nxt = 32'(wrap_sum - $signed({1'b0, wrap_len}));
      end else begin
         wrap_pos_nxt = 32'(wrap_sum);
      end
   end

   // Feedback position report picks the wrapped or the raw count
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fb_prev_r <= `WORD_ZERO;
         wrap_pos_r <= `WORD_ZERO;
         fb_report_r <= `WORD_ZERO;
      end else begin
         fb_prev_r <= fb_position;
         wrap_pos_r <= wrap_pos_nxt;
         fb_report_r <= wrap_en ? wrap_pos_nxt : fb_position; // RULE2
      end
   end

   // Load total saturates instead of wrapping back to a small value
   always_comb begin
      load_sum = {1'b0, load_acc_r} + {17'h0_0000, magnitude(load_sample)};
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         load_acc_r <= `WORD_ZERO;
      end else if (load_valid) begin
         load_acc_r <= load_sum[32] ? `LOAD_FULL : load_sum[31:0]; // RULE7
      end
   end

   // Run tracking; a new entry start wins over a completion
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_r <= RUN_IDLE;
      end else begin
         unique case (run_r)
            RUN_IDLE: begin
               if (op_start) begin
                  run_r <= RUN_ACTIVE;
               end
            end
            RUN_ACTIVE: begin
               if (op_done && !op_start) begin
                  run_r <= RUN_IDLE;
               end
            end
         endcase
      end
   end

   assign op_running = (run_r == RUN_ACTIVE);

   // Successor is fixed at each entry start, target only at starts of the eight listed move kinds; both then held
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         target_r <= `WORD_ZERO;
         next_no_r <= `ENTRY_NONE;
      end else if (op_start) begin
         if (shows_destination(op_kind)) begin
            target_r <= op_destination; // RULE8
         end else if (shows_start(op_kind)) begin
            target_r <= cmd_position; // RULE9
         end
         if (entry_link_mode == `LINK_NONE ||
             entry_next_no == `NEXT_FIELD_STOP) begin
            next_no_r <= `ENTRY_NONE; // RULE11
         end else begin
            next_no_r <= {16'h0000, entry_next_no}; // RULE10
         end
      end
   end

   // Loop state; stop or end of operation returns the idle values
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         loop_origin_r <= `ENTRY_NONE;
         loop_count_r <= `WORD_ZERO;
      end else if (loop_stop || (op_done && !op_start)) begin
         loop_origin_r <= `ENTRY_NONE; // RULE12
         loop_count_r <= `WORD_ZERO; // RULE13
      end else if (loop_begin) begin
         loop_origin_r <= {16'h0000, loop_origin_no}; // RULE12
         loop_count_r <= `WORD_ZERO;
      end else if (loop_pass && loop_origin_r != `ENTRY_NONE) begin
         loop_count_r <= loop_count_r + 32'h0000_0001; // RULE13
      end
   end

   // Capture latch sees the feedback value the host reads and the live command position
   assign cap.adv_pulse = advance_event;
   assign cap.clear_pulse = capture_clear;
   assign cap.cmd_pos = cmd_position;
   assign cap.fb_pos = fb_report_r;

   advance_capture capture_u (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cap(cap)
   );

   // Address decode on the upper word of each pair
   always_comb begin
      upper_addr = {rd_addr[15:1], 1'b0};
      rd_lower = rd_addr[0];
      sel_hit = 1'b1;
      unique case (upper_addr)
         `ADDR_CMD_SPEED_HZ: sel_word = cmd_speed_r;
         `ADDR_FB_POSITION: sel_word = fb_report_r;
         `ADDR_FB_SPEED_RPM: sel_word = rpm_r;
         `ADDR_FB_SPEED_HZ: sel_word = fb_hz_r;
         `ADDR_DWELL_MS: sel_word = dwell_r;
         `ADDR_PIN_STATE: sel_word = pins_r;
         `ADDR_TORQUE: sel_word = torque_r;
         `ADDR_LOAD: sel_word = load_acc_r;
         `ADDR_DESTINATION: sel_word = target_r;
         `ADDR_SUCCESSOR: sel_word = next_no_r;
         `ADDR_LOOP_START: sel_word = loop_origin_r;
         `ADDR_LOOP_ITER: sel_word = loop_count_r;
         `ADDR_CAP_CMD: sel_word = cap.held_cmd;
         `ADDR_CAP_FB: sel_word = cap.held_fb;
         default: begin
            sel_word = `WORD_ZERO;
            sel_hit = 1'b0;
         end
      endcase
   end

   // Upper read freezes the lower half so the pair stays coherent
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lo_hold_r <= `WORD_ZERO;
         lo_hold_addr_r <= `HALF_ZERO;
         lo_hold_valid_r <= 1'b0;
      end else if (rd_en && sel_hit) begin
         if (!rd_lower) begin
            lo_hold_r <= sel_word; // RULE18
            lo_hold_addr_r <= {upper_addr[15:1], 1'b1};
            lo_hold_valid_r <= 1'b1;
         end else begin
            lo_hold_valid_r <= 1'b0;
         end
      end
   end

   // Read answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data <= `HALF_ZERO;
         rd_valid <= 1'b0;
         rd_err <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         rd_err <= rd_en && !sel_hit;
         if (rd_en) begin
            if (rd_lower && lo_hold_valid_r && rd_addr == lo_hold_addr_r) begin
               rd_data <= lo_hold_r[15:0]; // RULE18
            end else begin
               rd_data <= half_of(sel_word, rd_lower); // RULE18
            end
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   successor_none_a: assert property (op_start && // RULE11
      (entry_link_mode == `LINK_NONE || entry_next_no == `NEXT_FIELD_STOP)
      |=> next_no_r == `ENTRY_NONE)
      else $error("successor not -1 for unlinked entry");
   successor_kept_a: assert property (op_done && !op_start // RULE10
      |=> next_no_r == $past(next_no_r) ##1
      ($past(op_start) || next_no_r == $past(next_no_r, 2)))
      else $error("successor number lost after completion");
   target_dest_a: assert property (op_start && // RULE8
      shows_destination(op_kind) |=> target_r == $past(op_destination))
      else $error("target does not hold destination");
   target_start_a: assert property (op_start && // RULE9
      shows_start(op_kind) |=> target_r == $past(cmd_position))
      else $error("target does not hold start position");
   loop_idle_a: assert property (loop_stop |=> // RULE12
      loop_origin_r == `ENTRY_NONE && loop_count_r == `WORD_ZERO)
      else $error("stopped loop not idle");
   loop_step_a: assert property (loop_pass && !loop_stop && // RULE13
      !loop_begin && !op_done && loop_origin_r != `ENTRY_NONE
      |=> loop_count_r == $past(loop_count_r) + 32'h0000_0001)
      else $error("loop count did not step by one");
   load_grow_a: assert property (load_valid |=> // RULE7
      load_acc_r >= $past(load_acc_r))
      else $error("load total decreased");
   read_answer_a: assert property (rd_en && sel_hit |=> // RULE18
      rd_valid && !rd_err)
      else $error("mapped read not answered");
   read_unmapped_a: assert property (rd_en && !sel_hit |=>
      rd_valid && rd_err && rd_data == `HALF_ZERO)
      else $error("unmapped read not flagged");
   speed_copy_a: assert property (1'b1 |=> // RULE1
      cmd_speed_r == $past(cmd_speed_hz) && rpm_r == $past(fb_speed_rpm))
      else $error("speed monitor stale");

   pair_read_c: cover property (rd_en && !rd_lower && sel_hit ##1
      rd_en && rd_lower && rd_addr == lo_hold_addr_r);
   loop_run_c: cover property (loop_begin ##[1:20] loop_pass);
   capture_c: cover property (advance_event ##[1:20] capture_clear);
   linked_c: cover property (op_start && next_no_r != `ENTRY_NONE);
endmodule : motion_monitor_registers
`default_nettype wire
